//--- sim/mrf_monitor.sv
`timescale 1ns/1ps
module mrf_monitor (
  input wire logic                    clk,        // Clock
  input wire logic                    srst,       // Reset
  input wire logic                    overflow,   // Lost sample
  input wire logic                    resValid,   // Result valid
  input wire logic [mrf_pkg::CHW-1:0] resChan,    // Result channel
  input wire mrf_pkg::mrf_lanes_t     resData,    // Result lanes
  input wire logic [mrf_pkg::AW-1:0]  cfgAddr,    // Coef address
  input wire logic                    cfgWrite,   // Write strobe
  input wire logic                    cfgRead,    // Read strobe
  input wire logic [mrf_pkg::CW-1:0]  cfgWrData,  // Write data
  input wire logic [mrf_pkg::CW-1:0]  cfgRdData,  // Read data
  input wire logic                    cfgRdValid  // Read answer
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Address falls in the coefficient window
  logic inRng;  // In range
  assign inRng = (cfgAddr >= mrf_pkg::COEF_BASE) && (cfgAddr < mrf_pkg::COEF_BASE + 8'h18);
  rst_clear_a: assert property (disable iff (1'b0) srst |=> !resValid && !cfgRdValid && !overflow)
    else $error("outputs not cleared by reset");
  rd_answer_a: assert property (cfgRead |=> cfgRdValid)
    else $error("read got no answer");
  rd_cause_a: assert property (cfgRdValid |-> $past(cfgRead))
    else $error("read answer without request");
  rd_empty_a: assert property (cfgRead && !inRng |=> cfgRdData == 16'h0000)
    else $error("unmapped read not zero");
  wr_read_a: assert property (cfgWrite && inRng ##1 cfgRead && $stable(cfgAddr)
    |=> cfgRdData == $past(cfgWrData, 2))
    else $error("written coefficient not read back");
  res_pulse_a: assert property (resValid |=> !resValid)
    else $error("result valid longer than one cycle");
  // Result word and tag were settled before the strobe rose
  res_hold_a: assert property (resValid |-> $stable(resData) && $stable(resChan))
    else $error("result changed with its strobe");
  // A full four-product pass lies between two results
  res_gap_a: assert property (resValid |=> !resValid [*5])
    else $error("results closer than one product pass");
  ovf_sticky_a: assert property (overflow |=> overflow)
    else $error("overflow flag dropped");
endmodule

//--- sim/mrf_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, s) begin cmp_count++; if ((e) !== (s)) begin mismatches++; $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module mrf_tb;
  logic                    clk = 1'b0;          // Clock
  logic                    srst = 1'b1;         // Reset
  logic                    usrValid = 1'b0;     // Sample valid
  logic [mrf_pkg::CHW-1:0] usrChan = '0;        // Slot tag
  logic [mrf_pkg::DW-1:0]  usrData = '0;        // Sample
  logic [mrf_pkg::MDW-1:0] usrMode = '0;        // Mapping mode
  logic [mrf_pkg::BKW-1:0] usrBank = '0;        // Bank
  logic [mrf_pkg::CIW-1:0] usrCoefIdx = '0;     // Coef index
  logic                    usrCoefWr = 1'b0;    // Write request
  logic                    usrCoefRd = 1'b0;    // Read request
  logic [mrf_pkg::CW-1:0]  usrCoefWdata = '0;   // Write data
  logic                    usrResValid;         // Result valid
  logic [mrf_pkg::CHW-1:0] usrResChan;          // Result channel
  mrf_pkg::mrf_lanes_t     usrResData;          // Result lanes
  logic                    usrCoefRvalid;       // Read answer valid
  logic [mrf_pkg::CW-1:0]  usrCoefRdata;        // Read answer
  logic                    usrRoom;             // Buffer room
  logic                    usrOverflow;         // Lost sample
  int                      mismatches = 0;      // Failed compares
  int                      cmp_count = 0;       // All compares
  logic signed [mrf_pkg::CW-1:0] cf [mrf_pkg::NCOEF];    // Coef shadow
  logic signed [mrf_pkg::DW-1:0] hist [mrf_pkg::NCH][4]; // History shadow
  logic                    vpar [mrf_pkg::NCH]; // Virtual index parity
  logic [mrf_pkg::OW:0]    expQ [$];            // Expected results
  logic [mrf_pkg::OW:0]    gotQ [$];            // Seen results
  always #5 clk = ~clk;
  mrf_if mrf_if_i (.clk(clk));
  mrf_device mrf_device_i (.bus(mrf_if_i));
  mrf_host mrf_host_i (.bus(mrf_if_i), .srst(srst), .usrValid(usrValid), .usrChan(usrChan),
    .usrData(usrData), .usrMode(usrMode), .usrBank(usrBank), .usrCoefIdx(usrCoefIdx),
    .usrCoefWr(usrCoefWr), .usrCoefRd(usrCoefRd), .usrCoefWdata(usrCoefWdata),
    .usrResValid(usrResValid), .usrResChan(usrResChan), .usrResData(usrResData),
    .usrCoefRvalid(usrCoefRvalid), .usrCoefRdata(usrCoefRdata), .usrRoom(usrRoom),
    .usrOverflow(usrOverflow));
  mrf_monitor mrf_monitor_i (.clk(clk), .srst(mrf_if_i.srst), .overflow(mrf_if_i.overflow),
    .resValid(mrf_if_i.resValid), .resChan(mrf_if_i.resChan), .resData(mrf_if_i.resData),
    .cfgAddr(mrf_if_i.cfgAddr), .cfgWrite(mrf_if_i.cfgWrite), .cfgRead(mrf_if_i.cfgRead),
    .cfgWrData(mrf_if_i.cfgWrData), .cfgRdData(mrf_if_i.cfgRdData),
    .cfgRdValid(mrf_if_i.cfgRdValid));
  // Collects every result on the user side
  always @(posedge clk)
  begin
    if (usrResValid === 1'b1)
      gotQ.push_back({usrResChan, usrResData[0]});
  end
  // Verdict and end of run
  task report_and_stop;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Steps just past a rising edge
  task tick;
    @(posedge clk);
    #1;
  endtask
  // Reset for eight cycles, shadows back to start
  task do_reset;
    srst = 1'b1;
    repeat (8) tick;
    srst = 1'b0;
    cf = mrf_pkg::COEF_INIT;
    hist = '{default: '0};
    vpar = '{default: 1'b0};
    expQ.delete();
    gotQ.delete();
  endtask
  // One coefficient write
  task wr(input logic [4:0] idx, input logic [15:0] val);
    usrCoefIdx = idx;
    usrCoefWdata = val;
    usrCoefWr = 1'b1;
    tick;
    usrCoefWr = 1'b0;
    cf[idx] = val;
  endtask
  // One coefficient read, bounded wait for the answer
  task rd(input logic [4:0] idx, input logic [15:0] ev);
    int n;
    usrCoefIdx = idx;
    usrCoefRd = 1'b1;
    tick;
    usrCoefRd = 1'b0;
    for (n = 0; n < 10 && usrCoefRvalid !== 1'b1; n++) tick;
    if (n == 10)
    begin
      mismatches++;
      report_and_stop();
    end
    else
      `CHK("coef read", ev, usrCoefRdata)
  endtask
  // One sample; expected results from the stuffed-zero model
  task send(input logic slot, input logic [15:0] x);
    int ch;
    int j;
    logic signed [mrf_pkg::OW-1:0] acc;
    ch = mrf_pkg::CHMAP[usrMode][slot];
    for (j = 3; j > 0; j--) hist[ch][j] = hist[ch][j-1];
    hist[ch][0] = x;
    for (int p = 0; p < 3; p++)
    begin
      // Only even virtual indices survive decimation
      if (((vpar[ch] + p) % 2) == 0)
      begin
        acc = '0;
        for (j = 0; j < 4; j++) acc = acc + cf[usrBank * 12 + p + 3 * j] * hist[ch][j];
        expQ.push_back({ch[0], acc});
      end
    end
    vpar[ch] = ~vpar[ch];
    usrValid = 1'b1;
    usrChan = slot;
    usrData = x;
    tick;
    usrValid = 1'b0;
    repeat (20) tick;
  endtask
  // Compares collected results with the model
  task chk_res;
    `CHK("result count", expQ.size(), gotQ.size())
    foreach (expQ[k])
    begin
      if (k < gotQ.size())
        `CHK("result", expQ[k], gotQ[k])
    end
  endtask
  // Clean state after reset
  task t_reset;
    do_reset;
    repeat (3) tick;
    `CHK("room", 1'b1, usrRoom)
    `CHK("overflow", 1'b0, usrOverflow)
    `CHK("res valid", 1'b0, usrResValid)
  endtask
  // Coefficient window, write then read back, unmapped read
  task t_coef;
    do_reset;
    rd(5'h00, mrf_pkg::COEF_INIT[0]);
    rd(5'h17, mrf_pkg::COEF_INIT[23]);
    wr(5'h05, 16'h1234);
    rd(5'h05, 16'h1234);
    rd(5'h18, 16'h0000);
  endtask
  // Filtering with an updated tap and extreme samples
  task t_filter;
    do_reset;
    wr(5'h00, 16'hfff9);
    send(1'b0, 16'h0003);
    send(1'b0, 16'h8000);
    send(1'b1, 16'h7fff);
    send(1'b0, 16'h0005);
    chk_res;
  endtask
  // Swapped mapping with the second bank, then back
  task t_map;
    do_reset;
    usrMode = 1'b1;
    usrBank = 1'b1;
    send(1'b0, 16'h0100);
    send(1'b1, 16'hff00);
    usrMode = 1'b0;
    send(1'b0, 16'h0007);
    chk_res;
    usrBank = 1'b0;
  endtask
  // Burst overruns the buffer, then drains
  task t_burst;
    logic roomLow;
    do_reset;
    roomLow = 1'b0;
    usrValid = 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      usrData = 16'h0010 + i[15:0];
      tick;
      if (usrRoom === 1'b0)
        roomLow = 1'b1;
    end
    usrValid = 1'b0;
    repeat (4) tick;
    `CHK("room low", 1'b1, roomLow)
    `CHK("overflow", 1'b1, usrOverflow)
    repeat (300) tick;
    `CHK("room back", 1'b1, usrRoom)
    do_reset;
    repeat (2) tick;
    `CHK("overflow cleared", 1'b0, usrOverflow)
  endtask
  // Main sequence
  initial
  begin
    t_reset;
    t_coef;
    t_filter;
    t_map;
    t_burst;
    report_and_stop();
  end
  // Hang guard
  initial
  begin
    #500000;
    mismatches++;
    report_and_stop();
  end
endmodule

//--- verilog/mrf_device.sv
`timescale 1ns/1ps
module mrf_fifo #(
  parameter int W     = 8,  // Word width
  parameter int DEPTH = 8   // Word count
) (
  input  wire logic         clk,      // Clock
  input  wire logic         srst,     // Synchronous reset
  input  wire logic         inValid,  // Word offered
  output logic              inReady,  // Room for a word
  input  wire logic [W-1:0] inData,   // Offered word
  output logic              outValid, // Word available
  input  wire logic         outReady, // Drain takes word
  output logic [W-1:0]      outData   // Oldest word
);
  localparam int PTRW = $clog2(DEPTH);
  logic [W-1:0]    mem_reg [DEPTH];   // Storage
  logic [PTRW-1:0] wrPtr_reg;         // Write pointer
  logic [PTRW-1:0] rdPtr_reg;         // Read pointer
  logic [PTRW:0]   count_reg;         // Fill level
  logic [PTRW-1:0] wrPtr_next;
  logic [PTRW-1:0] rdPtr_next;
  logic [PTRW:0]   count_next;
  logic            push;
  logic            pop;
  assign inReady  = (count_reg != (PTRW+1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign outData  = mem_reg[rdPtr_reg];
  // Pointer and level update
  always_comb
  begin
    push       = inValid && inReady;
    pop        = outValid && outReady;
    wrPtr_next = push ? PTRW'((32'(wrPtr_reg) + 1) % DEPTH) : wrPtr_reg;
    rdPtr_next = pop ? PTRW'((32'(rdPtr_reg) + 1) % DEPTH) : rdPtr_reg;
    count_next = count_reg + (PTRW+1)'(push) - (PTRW+1)'(pop);
  end
  // Register pointers and storage
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      count_reg <= count_next;
      if (push)
        mem_reg[wrPtr_reg] <= inData;
    end
  end
endmodule

module mrf_device (
  mrf_if.dev bus  // Link to streaming and coefficient host
);
  typedef logic signed [mrf_pkg::DW-1:0] mrf_smp_t;
  mrf_pkg::mrf_state_t      state_reg, state_next;     // Engine state
  mrf_smp_t                 hist_reg [mrf_pkg::NCH][mrf_pkg::HDEPTH]; // Histories
  mrf_smp_t                 hist_next [mrf_pkg::NCH][mrf_pkg::HDEPTH];
  logic [mrf_pkg::PW-1:0]   ph_reg [mrf_pkg::NCH];     // Virtual index mod D
  logic [mrf_pkg::PW-1:0]   ph_next [mrf_pkg::NCH];
  logic [mrf_pkg::CHW-1:0]  ch_reg, ch_next;           // Channel in work
  mrf_smp_t                 smp_reg, smp_next;         // Sample in work
  logic [mrf_pkg::BKW-1:0]  bank_reg, bank_next;       // Bank latched per sample
  logic [mrf_pkg::PW-1:0]   pIdx_reg, pIdx_next;       // Stuffing phase
  logic [mrf_pkg::HW-1:0]   j_reg, j_next;             // History index
  logic signed [mrf_pkg::OW-1:0] acc_reg, acc_next;    // Accumulator
  logic                     resValid_reg, resValid_next; // Result strobe
  logic signed [mrf_pkg::CW-1:0] coef_reg [mrf_pkg::NCOEF]; // Coefficient store
  logic signed [mrf_pkg::CW-1:0] coef_next [mrf_pkg::NCOEF];
  logic [mrf_pkg::CW-1:0]   rdData_reg, rdData_next;   // Read answer
  logic                     rdValid_reg, rdValid_next; // Read answer strobe
  logic                     ovf_reg, ovf_next;         // Lost sample flag
  logic                     room_reg;                  // Registered room
  logic                     fifoReady, fifoValid, fifoPop;
  logic [mrf_pkg::FW-1:0]   fifoData;
  logic [mrf_pkg::AW-1:0]   cIdx;
  logic                     cHit;
  int                       tap;

  // Nyquist structures have zeros away from the centre at multiples of L
  function automatic logic tapZero(input int k);
    int d;
    d = (k > mrf_pkg::CENTER) ? k - mrf_pkg::CENTER : mrf_pkg::CENTER - k;
    return (mrf_pkg::TAP_STRUCT >= 2) && (d != 0) && ((d % mrf_pkg::TAP_STRUCT) == 0);
  endfunction

  // A valid sample is pushed only while the buffer has room; no stall goes upstream
  mrf_fifo #(.W(mrf_pkg::FW), .DEPTH(mrf_pkg::FIFO_DEPTH)) mrf_fifo_i (
    .clk      (bus.clk),
    .srst     (bus.srst),
    .inValid  (bus.smpValid),
    .inReady  (fifoReady),
    .inData   ({bus.smpChan, bus.smpData}),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoData)
  );

  assign fifoPop = (state_reg == mrf_pkg::ST_IDLE) && fifoValid;
  assign tap     = 32'(pIdx_reg) + 32'(j_reg) * mrf_pkg::IFAC;
  assign cIdx    = bus.cfgAddr - mrf_pkg::COEF_BASE;
  assign cHit    = (bus.cfgAddr >= mrf_pkg::COEF_BASE) &&
                   (32'(cIdx) < mrf_pkg::NCOEF);

  // Polyphase engine next state
  always_comb
  begin
    state_next    = state_reg;
    hist_next     = hist_reg;
    ph_next       = ph_reg;
    ch_next       = ch_reg;
    smp_next      = smp_reg;
    bank_next     = bank_reg;
    pIdx_next     = pIdx_reg;
    j_next        = j_reg;
    acc_next      = acc_reg;
    resValid_next = 1'b0;
    case (state_reg)
      mrf_pkg::ST_IDLE:
      begin
        if (fifoValid)
        begin
          // Slot tag goes through the mode's mapping row
          ch_next    = mrf_pkg::CHMAP[bus.modeSel][fifoData[mrf_pkg::FW-1 -: mrf_pkg::CHW]];
          smp_next   = fifoData[mrf_pkg::DW-1:0];
          bank_next  = bus.bankSel;
          state_next = mrf_pkg::ST_LOAD;
        end
      end
      mrf_pkg::ST_LOAD:
      begin
        // Shift newest sample into the channel history
        for (int h = mrf_pkg::HDEPTH - 1; h > 0; h--)
          hist_next[ch_reg][h] = hist_reg[ch_reg][h-1];
        hist_next[ch_reg][0] = smp_reg;
        pIdx_next  = '0;
        state_next = mrf_pkg::ST_PHASE;
      end
      mrf_pkg::ST_PHASE:
      begin
        if (32'(pIdx_reg) == mrf_pkg::IFAC)
          state_next = mrf_pkg::ST_IDLE;
        else if (ph_reg[ch_reg] == '0)
        begin
          // Kept output: compute it
          acc_next   = '0;
          j_next     = '0;
          state_next = mrf_pkg::ST_MAC;
        end
        else
        begin
          // Dropped output: no products at all
          ph_next[ch_reg] = mrf_pkg::PW'((32'(ph_reg[ch_reg]) + 1) % mrf_pkg::DFAC);
          pIdx_next       = pIdx_reg + 1'b1;
        end
      end
      mrf_pkg::ST_MAC:
      begin
        // Only taps landing on real samples, and not known zeros
        if (tap < mrf_pkg::NTAP && !tapZero(tap))
          acc_next = acc_reg + mrf_pkg::OW'(coef_reg[32'(bank_reg) * mrf_pkg::NTAP + tap]) *
                     mrf_pkg::OW'(hist_reg[ch_reg][j_reg]);
        j_next = j_reg + 1'b1;
        if (32'(j_reg) == mrf_pkg::HDEPTH - 1)
          state_next = mrf_pkg::ST_EMIT;
      end
      mrf_pkg::ST_EMIT:
      begin
        resValid_next   = 1'b1;
        ph_next[ch_reg] = mrf_pkg::PW'((32'(ph_reg[ch_reg]) + 1) % mrf_pkg::DFAC);
        pIdx_next       = pIdx_reg + 1'b1;
        state_next      = mrf_pkg::ST_PHASE;
      end
      default:
        state_next = mrf_pkg::ST_IDLE;
    endcase
  end

  // Coefficient port next values
  always_comb
  begin
    coef_next    = coef_reg;
    rdData_next  = '0;
    rdValid_next = 1'b0;
    ovf_next     = ovf_reg || (bus.smpValid && !fifoReady);
    if (mrf_pkg::COEF_ACCESS != mrf_pkg::ACC_CONST)
    begin
      if (bus.cfgWrite && cHit && mrf_pkg::COEF_ACCESS != mrf_pkg::ACC_RO)
        coef_next[cIdx[mrf_pkg::CIW-1:0]] = bus.cfgWrData;
      if (bus.cfgRead)
      begin
        rdValid_next = 1'b1;
        if (cHit && mrf_pkg::COEF_ACCESS != mrf_pkg::ACC_WO)
          rdData_next = coef_reg[cIdx[mrf_pkg::CIW-1:0]];
      end
    end
  end

  // Register engine and coefficient state
  always_ff @(posedge bus.clk)
  begin
    if (bus.srst)
    begin
      state_reg    <= mrf_pkg::ST_IDLE;
      for (int c = 0; c < mrf_pkg::NCH; c++)
      begin
        ph_reg[c] <= '0;
        for (int h = 0; h < mrf_pkg::HDEPTH; h++)
          hist_reg[c][h] <= '0;
      end
      ch_reg       <= '0;
      smp_reg      <= '0;
      bank_reg     <= '0;
      pIdx_reg     <= '0;
      j_reg        <= '0;
      acc_reg      <= '0;
      resValid_reg <= 1'b0;
      coef_reg     <= mrf_pkg::COEF_INIT;
      rdData_reg   <= '0;
      rdValid_reg  <= 1'b0;
      ovf_reg      <= 1'b0;
      room_reg     <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      hist_reg     <= hist_next;
      ph_reg       <= ph_next;
      ch_reg       <= ch_next;
      smp_reg      <= smp_next;
      bank_reg     <= bank_next;
      pIdx_reg     <= pIdx_next;
      j_reg        <= j_next;
      acc_reg      <= acc_next;
      resValid_reg <= resValid_next;
      coef_reg     <= coef_next;
      rdData_reg   <= rdData_next;
      rdValid_reg  <= rdValid_next;
      ovf_reg      <= ovf_next;
      room_reg     <= fifoReady;
    end
  end

  assign bus.resValid   = resValid_reg;
  assign bus.resChan    = ch_reg;
  assign bus.resData    = {mrf_pkg::NLANE{acc_reg}};
  assign bus.cfgRdData  = rdData_reg;
  assign bus.cfgRdValid = rdValid_reg;
  assign bus.overflow   = ovf_reg;
  assign bus.inRoom     = room_reg;
endmodule

//--- verilog/mrf_host.sv
`timescale 1ns/1ps
module mrf_host (
  mrf_if.host                    bus,         // Link to filter
  input  wire logic              srst,        // Synchronous reset
  input  wire logic              usrValid,    // User sample valid
  input  wire logic [mrf_pkg::CHW-1:0] usrChan, // User slot tag
  input  wire logic [mrf_pkg::DW-1:0]  usrData, // User sample
  input  wire logic [mrf_pkg::MDW-1:0] usrMode, // Mapping mode
  input  wire logic [mrf_pkg::BKW-1:0] usrBank, // Coefficient bank
  input  wire logic [mrf_pkg::CIW-1:0] usrCoefIdx, // Coefficient index
  input  wire logic              usrCoefWr,   // Write request
  input  wire logic              usrCoefRd,   // Read request
  input  wire logic [mrf_pkg::CW-1:0]  usrCoefWdata, // Write data
  output logic                   usrResValid, // Result valid
  output logic [mrf_pkg::CHW-1:0] usrResChan, // Result channel
  output mrf_pkg::mrf_lanes_t    usrResData,  // Result lanes
  output logic                   usrCoefRvalid, // Read answer valid
  output logic [mrf_pkg::CW-1:0] usrCoefRdata, // Read answer
  output logic                   usrRoom,     // Filter buffer has room
  output logic                   usrOverflow  // Filter lost a sample
);
  logic                   sValid_reg;   // Link sample valid
  logic [mrf_pkg::CHW-1:0] sChan_reg;   // Link slot tag
  logic [mrf_pkg::DW-1:0]  sData_reg;   // Link sample
  logic [mrf_pkg::MDW-1:0] mode_reg;    // Link mode
  logic [mrf_pkg::BKW-1:0] bank_reg;    // Link bank
  logic [mrf_pkg::AW-1:0]  addr_reg;    // Link address
  logic                   wr_reg;       // Link write
  logic                   rd_reg;       // Link read
  logic [mrf_pkg::CW-1:0]  wdata_reg;   // Link write data
  logic                   rv_reg;       // Result valid seen
  logic [mrf_pkg::CHW-1:0] rc_reg;      // Result channel held
  mrf_pkg::mrf_lanes_t    rd_data_reg;  // Result data held
  logic                   cv_reg;       // Read answer valid
  logic [mrf_pkg::CW-1:0]  cd_reg;      // Read answer held
  logic                   room_reg;     // Room seen
  logic                   ovf_reg;      // Overflow seen

  // Register link side and capture answers
  always_ff @(posedge bus.clk)
  begin
    if (srst)
    begin
      sValid_reg  <= 1'b0;
      sChan_reg   <= '0;
      sData_reg   <= '0;
      mode_reg    <= '0;
      bank_reg    <= '0;
      addr_reg    <= '0;
      wr_reg      <= 1'b0;
      rd_reg      <= 1'b0;
      wdata_reg   <= '0;
      rv_reg      <= 1'b0;
      rc_reg      <= '0;
      rd_data_reg <= '0;
      cv_reg      <= 1'b0;
      cd_reg      <= '0;
      room_reg    <= 1'b0;
      ovf_reg     <= 1'b0;
    end
    else
    begin
      sValid_reg <= usrValid;
      sChan_reg  <= usrValid ? usrChan : '0;
      sData_reg  <= usrValid ? usrData : '0;
      mode_reg   <= usrMode;
      bank_reg   <= usrBank;
      addr_reg   <= mrf_pkg::COEF_BASE + mrf_pkg::AW'(usrCoefIdx);
      wr_reg     <= usrCoefWr;
      rd_reg     <= usrCoefRd;
      wdata_reg  <= usrCoefWdata;
      rv_reg     <= bus.resValid;
      if (bus.resValid)
      begin
        // Result fields only trusted with valid
        rc_reg      <= bus.resChan;
        rd_data_reg <= bus.resData;
      end
      cv_reg <= bus.cfgRdValid;
      if (bus.cfgRdValid)
        cd_reg <= bus.cfgRdData;
      room_reg <= bus.inRoom;
      ovf_reg  <= bus.overflow;
    end
  end

  assign bus.srst      = srst;
  assign bus.smpValid  = sValid_reg;
  assign bus.smpChan   = sChan_reg;
  assign bus.smpData   = sData_reg;
  assign bus.modeSel   = mode_reg;
  assign bus.bankSel   = bank_reg;
  assign bus.cfgAddr   = addr_reg;
  assign bus.cfgWrite  = wr_reg;
  assign bus.cfgRead   = rd_reg;
  assign bus.cfgWrData = wdata_reg;
  assign usrResValid   = rv_reg;
  assign usrResChan    = rc_reg;
  assign usrResData    = rd_data_reg;
  assign usrCoefRvalid = cv_reg;
  assign usrCoefRdata  = cd_reg;
  assign usrRoom       = room_reg;
  assign usrOverflow   = ovf_reg;
endmodule

//--- verilog/mrf_if.sv
`timescale 1ns/1ps
interface mrf_if (
  input wire logic clk  // Shared clock
);
  logic                  srst;       // Synchronous reset
  logic                  smpValid;   // Input sample valid
  logic [mrf_pkg::CHW-1:0] smpChan;  // Input slot tag
  logic [mrf_pkg::DW-1:0]  smpData;  // Input sample
  logic [mrf_pkg::MDW-1:0] modeSel;  // Channel mapping mode
  logic [mrf_pkg::BKW-1:0] bankSel;  // Coefficient bank
  logic                  inRoom;     // Input buffer has room
  logic                  overflow;   // Sample lost, sticky
  logic                  resValid;   // Result valid
  logic [mrf_pkg::CHW-1:0] resChan;  // Result channel
  mrf_pkg::mrf_lanes_t   resData;    // Result lanes
  logic [mrf_pkg::AW-1:0]  cfgAddr;  // Coefficient address
  logic                  cfgWrite;   // Coefficient write strobe
  logic                  cfgRead;    // Coefficient read strobe
  logic [mrf_pkg::CW-1:0]  cfgWrData; // Write data
  logic [mrf_pkg::CW-1:0]  cfgRdData; // Read data
  logic                  cfgRdValid; // Read data valid
  modport dev (input clk, srst, smpValid, smpChan, smpData, modeSel, bankSel,
               cfgAddr, cfgWrite, cfgRead, cfgWrData,
               output inRoom, overflow, resValid, resChan, resData, cfgRdData, cfgRdValid);
  modport host (input clk, inRoom, overflow, resValid, resChan, resData, cfgRdData,
                cfgRdValid,
                output srst, smpValid, smpChan, smpData, modeSel, bankSel,
                cfgAddr, cfgWrite, cfgRead, cfgWrData);
endinterface

//--- verilog/mrf_pkg.sv
package mrf_pkg;
  localparam int DW          = 16;                    // Input sample width
  localparam int CW          = 16;                    // Coefficient width, 2..32 signed
  localparam int NTAP        = 12;                    // Taps per coefficient set
  localparam int IFAC        = 3;                     // Interpolation factor I
  localparam int DFAC        = 2;                     // Decimation factor D
  localparam int NCH         = 2;                     // Channels
  localparam int CHW         = 1;                     // Channel tag width
  localparam int NBANK       = 2;                     // Coefficient banks
  localparam int BKW         = 1;                     // Bank select width
  localparam int NMODE       = 2;                     // Channel mapping modes
  localparam int MDW         = 1;                     // Mode select width
  localparam int NLANE       = 1;                     // Output lanes
  localparam int HDEPTH      = (NTAP + IFAC - 1) / IFAC; // History per channel
  localparam int HW          = 2;                     // History index width
  localparam int PW          = 2;                     // Phase index width
  localparam int OW          = DW + CW + 4;           // Full precision output width
  localparam int AW          = 8;                     // Coefficient address width
  localparam int NCOEF       = NBANK * NTAP;          // Stored coefficients
  localparam int CIW         = 5;                     // Coefficient index width
  localparam logic [AW-1:0] COEF_BASE = 8'h10;        // First coefficient address
  localparam int FIFO_DEPTH  = 8;                     // Input buffer depth
  localparam int FW          = CHW + DW;              // Buffer word width
  // Coefficient access modes
  localparam int ACC_RO      = 0;
  localparam int ACC_WO      = 1;
  localparam int ACC_RW      = 2;
  localparam int ACC_CONST   = 3;
  localparam int COEF_ACCESS = ACC_RW;
  // Tap structure: 0 all taps, 2 half band, L for Lth band (3..46)
  localparam int STRUCT_ALL  = 0;
  localparam int TAP_STRUCT  = STRUCT_ALL;
  localparam int CENTER      = (NTAP - 1) / 2;        // Centre tap of Nyquist sets
  localparam logic signed [CW-1:0] COEF_INIT [NCOEF] = '{
    16'h0010, 16'h0020, 16'h0040, 16'h0080, 16'h0100, 16'h0200,
    16'h0200, 16'h0100, 16'h0080, 16'h0040, 16'h0020, 16'h0010,
    16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0006,
    16'h0006, 16'h0005, 16'h0004, 16'h0003, 16'h0002, 16'h0001};
  localparam logic [CHW-1:0] CHMAP [NMODE][NCH] = '{'{1'h0, 1'h1}, '{1'h1, 1'h0}};
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_LOAD  = 5'h02,
    ST_PHASE = 5'h04,
    ST_MAC   = 5'h08,
    ST_EMIT  = 5'h10
  } mrf_state_t;
  typedef logic [NLANE-1:0][OW-1:0] mrf_lanes_t;
endpackage
